// file: hdl/wwdt_pkg.sv
// package for the windowed watchdog timer: register map, fields, timing
package wwdt_pkg;

	// apb register byte offsets
	localparam logic [7:0] WWDT_CFG_OFF    = 8'h00; // config word image
	localparam logic [7:0] WWDT_RESET_CONTROL_REG_OFF   = 8'h04; // reset control image
	localparam logic [7:0] WWDT_CMD_OFF    = 8'h08; // instruction strobes
	localparam logic [7:0] WWDT_STATUS_OFF = 8'h0c; // live state, read only

	// config word fields
	localparam int WWDT_POST_LSB    = 0;
	localparam int WWDT_POST_W      = 4;
	localparam int WWDT_PRE_BIT     = 4;
	localparam int WWDT_WINDOW_DISABLE_BIT  = 6;
	localparam int WWDT_FUSEEN_BIT  = 7;
	localparam logic [7:0] WWDT_CFG_RESET = 8'hdf; // fuse on, no window, 1:128, 1:32768

	// reset control fields
	localparam int WWDT_IDLE_BIT    = 2;
	localparam int WWDT_SLEEP_BIT   = 3;
	localparam int WWDT_TO_BIT      = 4;
	localparam int WWDT_SWEN_BIT    = 5;

	// command strobe fields
	localparam int WWDT_CMD_CLR_BIT   = 0;
	localparam int WWDT_CMD_SLEEP_BIT = 1;
	localparam int WWDT_CMD_IDLE_BIT  = 2;

	// prescaler divisors
	localparam int WWDT_PRE_SHORT = 32;
	localparam int WWDT_PRE_LONG  = 128;
	localparam int WWDT_PRE_W     = 7;
	localparam int WWDT_POST_CNT_W = 15;

	// oscillator timing
	localparam int WWDT_OSC_KHZ    = 32;
	localparam int WWDT_PERIOD_SHORT_MS = 1;
	localparam int WWDT_PERIOD_LONG_MS  = 4;

	typedef enum logic [1:0] {
		WWDT_RUN,
		WWDT_SLEEP,
		WWDT_IDLE
	} wwdt_mode_e;

endpackage

// file: hdl/wwdt_sync.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module wwdt_sync (
	input  wire logic clk,  // system clock
	input  wire logic rst,  // synchronous reset, high
	input  wire logic din,  // asynchronous level
	output logic      dout  // synchronised level
);
	logic stage1;
	logic next_stage1;
	logic next_dout;

	always_comb begin
		next_stage1 = rst ? 1'b0 : din;
		next_dout   = rst ? 1'b0 : stage1;
	end

	always_ff @(posedge clk) begin
		stage1 <= next_stage1;
		dout   <= next_dout;
	end
endmodule
`default_nettype wire

// file: hdl/wwdt_top.sv
// windowed watchdog timer with apb register slave
// Contract
// R1: watchdog counts on low-power rc oscillator ticks
// R2: prescaler divides by 32 or 128
// R3: base period 1 ms or 4 ms
// R4: postscaler has 16 ratios up to 1:32768
// R5: device reset clears all counts
// R6: clock switch completion clears all counts
// R7: power-save instruction clears all counts
// R8: leaving sleep or idle clears all counts
// R9: clear instruction clears all counts
// R10: watchdog keeps counting in sleep and idle
// R11: time-out in sleep or idle wakes device
// R12: software clears sleep and idle bits
// R13: fuse enable forces watchdog on
// R14: time-out flag sticks until software clears it
// R15: soft enable bit controls watchdog when fuse off
// R16: device reset clears soft enable bit
// R17: software clears only in final quarter
// R18: early clear in window mode forces reset
// R19: prescale select one is 1:128
// R20: postscale code 1111 gives 1:32768, halving downward
// R21: window disable one means non-window mode
// R22: run-mode time-out resets device, sets flag
// R23: postscale ratio is two to the code
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module wwdt_top
	import wwdt_pkg::*;
#(
	parameter int POST_W = WWDT_POST_CNT_W // postscaler counter width
) (
	input  wire logic        clk,          // 10 MHz system clock
	input  wire logic        rst,          // synchronous device reset, high
	input  wire logic        lprcClk,      // low-power rc oscillator, asynchronous
	input  wire logic        clockSwitchDone, // pulse: clock switch completed
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb enable
	input  wire logic        pwrite,       // apb direction
	input  wire logic [7:0]  paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic      [31:0] prdata,       // apb read data
	output logic             pready,       // apb ready
	output logic             pslverr,      // apb error, unmapped address
	output logic             oscEnable,    // low-power rc oscillator enable
	output logic             watchdogReset,// one-cycle device reset request
	output logic             wakeUp,       // one-cycle wake from sleep or idle
	output logic             lowPower      // core is in sleep or idle
);
	// rising edges of the synchronised oscillator are the watchdog tick
	logic lprcSync;
	logic lprcPrev;
	logic next_lprcPrev;
	logic tick;

	wwdt_sync uSync (
		.clk  (clk),
		.rst  (rst),
		.din  (lprcClk),
		.dout (lprcSync)
	);

	assign tick = lprcSync & ~lprcPrev; // [R1]

	// register state
	logic [7:0]         cfg;
	logic               swEn;
	logic               toFlag;
	logic               sleepFlag;
	logic               idleFlag;
	wwdt_mode_e         mode;
	logic [WWDT_PRE_W-1:0] preCnt;
	logic [POST_W-1:0]  postCnt;
	logic [31:0]        next_prdata;
	logic               next_pready;
	logic               next_pslverr;
	logic [7:0]         next_cfg;
	logic               next_swEn;
	logic               next_toFlag;
	logic               next_sleepFlag;
	logic               next_idleFlag;
	wwdt_mode_e         next_mode;
	logic [WWDT_PRE_W-1:0] next_preCnt;
	logic [POST_W-1:0]  next_postCnt;
	logic               next_oscEnable;
	logic               next_watchdogReset;
	logic               next_wakeUp;
	logic               next_lowPower;

	// decoded configuration and derived terms
	logic               wdtEn;
	logic [WWDT_PRE_W-1:0] preLast;
	logic [POST_W-1:0]  postLast;
	logic               preWrap;
	logic               timeout;
	logic               windowOpen;
	logic               apbAccess;
	logic               apbWrite;
	logic               cmdClr;
	logic               cmdSleep;
	logic               cmdIdle;
	logic               countClear;
	logic               wakeEvent;
	logic [31:0]        statusWord;

	assign wdtEn = cfg[WWDT_FUSEEN_BIT] | swEn; // [R13] [R15]

	// divide-by-128 when set, else divide-by-32
	assign preLast = cfg[WWDT_PRE_BIT] ? WWDT_PRE_W'(WWDT_PRE_LONG - 1)
		: WWDT_PRE_W'(WWDT_PRE_SHORT - 1); // [R2] [R3] [R19]

	// terminal count is 2^code - 1, so code 0 wraps every prescaler tick
	assign postLast = POST_W'((32'h1 << cfg[WWDT_POST_LSB +: WWDT_POST_W]) - 32'h1); // [R4] [R20] [R23]

	assign preWrap = tick && (preCnt == preLast);
	assign timeout = wdtEn && preWrap && (postCnt == postLast);

	// window opens once three quarters of the period have elapsed;
	// elapsed ticks scale by the live prescale, not by the counter width
	assign windowOpen = ((32'(postCnt) * (32'(preLast) + 32'h1) + 32'(preCnt)) * 32'h4)
		>= ((32'(postLast) + 32'h1) * (32'(preLast) + 32'h1) * 32'h3); // [R18]

	assign apbAccess = psel & penable;
	assign apbWrite  = apbAccess & pwrite & ~pready;
	assign cmdClr    = apbWrite && paddr == WWDT_CMD_OFF && pwdata[WWDT_CMD_CLR_BIT]
		&& mode == WWDT_RUN;
	assign cmdSleep  = apbWrite && paddr == WWDT_CMD_OFF && pwdata[WWDT_CMD_SLEEP_BIT]
		&& mode == WWDT_RUN;
	assign cmdIdle   = apbWrite && paddr == WWDT_CMD_OFF && pwdata[WWDT_CMD_IDLE_BIT]
		&& mode == WWDT_RUN && !pwdata[WWDT_CMD_SLEEP_BIT];

	// a time-out in a low-power mode wakes the core and sets the time-out flag, without a reset
	assign wakeEvent = timeout && mode != WWDT_RUN; // [R10] [R11]

	assign countClear = clockSwitchDone // [R6]
		|| cmdSleep || cmdIdle // [R7]
		|| wakeEvent // [R8]
		|| cmdClr; // [R9]

	assign statusWord = {{(32 - POST_W - WWDT_PRE_W - 3){1'b0}}, windowOpen, wdtEn,
		mode == WWDT_RUN ? 1'b0 : 1'b1, postCnt, preCnt};

	always_comb begin
		next_lprcPrev = rst ? 1'b0 : lprcSync;
		next_cfg       = cfg;
		next_swEn      = swEn;
		next_toFlag    = toFlag;
		next_sleepFlag = sleepFlag;
		next_idleFlag  = idleFlag;
		next_mode      = mode;
		next_preCnt    = preCnt;
		next_postCnt   = postCnt;
		next_prdata    = prdata;
		next_pready    = 1'b0;
		next_pslverr   = 1'b0;
		next_watchdogReset = 1'b0;
		next_wakeUp    = 1'b0;

		// apb: one wait state, answer in the access cycle after the first
		if (apbAccess && !pready) begin
			next_pready = 1'b1;
			next_prdata = 32'h0;
			unique case (paddr)
				WWDT_CFG_OFF: begin
					if (pwrite)
						next_cfg = pwdata[7:0];
					else
						next_prdata = {24'h0, cfg};
				end
				WWDT_RESET_CONTROL_REG_OFF: begin
					if (pwrite) begin
						next_swEn      = pwdata[WWDT_SWEN_BIT]; // [R15]
						next_toFlag    = pwdata[WWDT_TO_BIT];
						next_sleepFlag = pwdata[WWDT_SLEEP_BIT]; // [R12]
						next_idleFlag  = pwdata[WWDT_IDLE_BIT]; // [R12]
					end else begin
						next_prdata = {26'h0, swEn, toFlag, sleepFlag, idleFlag, 2'b00};
					end
				end
				WWDT_CMD_OFF: begin
					next_prdata = 32'h0;
				end
				WWDT_STATUS_OFF: begin
					if (!pwrite)
						next_prdata = statusWord;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end

		// counters advance on oscillator ticks while enabled
		if (wdtEn && tick) begin
			if (preWrap) begin
				next_preCnt  = '0;
				next_postCnt = timeout ? '0 : postCnt + POST_W'(1);
			end else begin
				next_preCnt = preCnt + WWDT_PRE_W'(1);
			end
		end
		if (!wdtEn) begin
			next_preCnt  = '0;
			next_postCnt = '0;
		end

		unique case (mode)
			WWDT_RUN: begin
				if (cmdSleep) begin
					next_mode      = WWDT_SLEEP;
					next_sleepFlag = 1'b1;
				end else if (cmdIdle) begin
					next_mode     = WWDT_IDLE;
					next_idleFlag = 1'b1;
				end
			end
			WWDT_SLEEP, WWDT_IDLE: begin
				if (wakeEvent) begin
					next_mode   = WWDT_RUN; // [R11]
					next_wakeUp = 1'b1;
					next_toFlag = 1'b1;
				end
			end
			default: begin
				next_mode = WWDT_RUN;
			end
		endcase

		// set wins over a software clear in the same cycle
		if (timeout && mode == WWDT_RUN) begin
			next_toFlag        = 1'b1; // [R14] [R22]
			next_watchdogReset = 1'b1; // [R22]
		end

		// early clear in window mode is treated as a fault
		if (cmdClr && !cfg[WWDT_WINDOW_DISABLE_BIT] && wdtEn && !windowOpen)
			next_watchdogReset = 1'b1; // [R18] [R21]

		if (countClear) begin
			next_preCnt  = '0;
			next_postCnt = '0;
		end

		next_oscEnable = (next_cfg[WWDT_FUSEEN_BIT] | next_swEn); // [R1]
		next_lowPower  = next_mode != WWDT_RUN;

		// device reset clears counts, soft enable and the time-out, sleep and idle flags
		if (rst) begin
			next_cfg       = WWDT_CFG_RESET;
			next_swEn      = 1'b0; // [R16]
			next_preCnt    = '0; // [R5]
			next_postCnt   = '0; // [R5]
			next_mode      = WWDT_RUN;
			next_toFlag    = 1'b0;
			next_sleepFlag = 1'b0;
			next_idleFlag  = 1'b0;
			next_prdata    = 32'h0;
			next_pready    = 1'b0;
			next_pslverr   = 1'b0;
			next_watchdogReset = 1'b0;
			next_wakeUp    = 1'b0;
			next_oscEnable = WWDT_CFG_RESET[WWDT_FUSEEN_BIT];
			next_lowPower  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		lprcPrev      <= next_lprcPrev;
		cfg           <= next_cfg;
		swEn          <= next_swEn;
		toFlag        <= next_toFlag;
		sleepFlag     <= next_sleepFlag;
		idleFlag      <= next_idleFlag;
		mode          <= next_mode;
		preCnt        <= next_preCnt;
		postCnt       <= next_postCnt;
		prdata        <= next_prdata;
		pready        <= next_pready;
		pslverr       <= next_pslverr;
		oscEnable     <= next_oscEnable;
		watchdogReset <= next_watchdogReset;
		wakeUp        <= next_wakeUp;
		lowPower      <= next_lowPower;
	end
endmodule
`default_nettype wire

// file: bench/wwdt_assertions.sv
// port checker for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module wwdt_assertions
	import wwdt_pkg::*;
(
	input wire logic        clk,           // clock
	input wire logic        rst,           // reset
	input wire logic        psel,          // select
	input wire logic        penable,       // enable
	input wire logic        pwrite,        // direction
	input wire logic [7:0]  paddr,         // address
	input wire logic [31:0] pwdata,        // write data
	input wire logic [31:0] prdata,        // read data
	input wire logic        pready,        // ready
	input wire logic        pslverr,       // error
	input wire logic        oscEnable,     // osc on
	input wire logic        watchdogReset, // reset request
	input wire logic        wakeUp,        // wake pulse
	input wire logic        lowPower       // asleep
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_reset_quiet: assert property ($fell(rst) |-> !pready && !wakeUp && oscEnable)
		else $error("outputs not idle after reset");
	chk_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("ready not after one wait");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_unmapped: assert property (psel && $rose(penable) && paddr > 8'h0c |=> pslverr)
		else $error("unmapped access not refused");
	chk_cmd_zero: assert property (pready && !pwrite && paddr == WWDT_CMD_OFF |-> prdata == 32'h0)
		else $error("command read not zero");
	chk_wdr_pulse: assert property (watchdogReset |=> !watchdogReset)
		else $error("reset request not a pulse");
	chk_wake_exit: assert property (wakeUp |-> $past(lowPower) ##1 !wakeUp && !lowPower)
		else $error("wake without leaving low power");
	chk_no_wdr_asleep: assert property (watchdogReset |-> !$past(lowPower))
		else $error("reset request while asleep");
	chk_sleep_entry: assert property (pready && pwrite && !pslverr && paddr == WWDT_CMD_OFF
		&& |pwdata[2:1] |-> ##[0:2] lowPower)
		else $error("power save not entered");
	cover property (wakeUp);
	cover property (watchdogReset);
	cover property (pslverr);
endmodule
bind wwdt_top wwdt_assertions u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .oscEnable(oscEnable), .watchdogReset(watchdogReset),
	.wakeUp(wakeUp), .lowPower(lowPower));
`default_nettype wire

// file: bench/wwdt_core_model.sv
// processor core stand-in issuing register transfers
`timescale 1ns/1ns
`default_nettype none
module wwdt_core_model (
	input  wire logic        clk,     // clock
	input  wire logic [31:0] prdata,  // read data
	input  wire logic        pready,  // ready
	input  wire logic        pslverr, // error
	output logic             psel,    // select
	output logic             penable, // enable
	output logic             pwrite,  // direction
	output logic      [7:0]  paddr,   // address
	output logic      [31:0] pwdata   // write data
);
	logic hung = 1'b0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// ready and data are taken at the rising edge that shows ready high
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) hung = 1'b1;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge clk);
	endtask
	// hardware leaves the mode flags set after a wake
	task automatic clear_status;
		logic [31:0] q;
		logic e;
		xfer(1'b1, 8'h04, 32'h0, q, e);
	endtask
endmodule
`default_nettype wire

// file: bench/wwdt_top_tb.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module wwdt_top_tb;
	import wwdt_pkg::*;
	logic clk = 0, rst = 1, lprcClk = 0, clockSwitchDone = 0;
	logic psel, penable, pwrite, pready, pslverr, e;
	logic oscEnable, watchdogReset, wakeUp, lowPower;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int err_total = 0, samples_checked = 0, wdrSeen = 0, wakeSeen = 0, n, b;
	always #50 clk = ~clk;
	always #400 lprcClk = ~lprcClk; // 8 clk per tick, off the rising edge
	always @(posedge clk) begin
		if (watchdogReset === 1'b1) wdrSeen <= wdrSeen + 1;
		if (wakeUp === 1'b1) wakeSeen <= wakeSeen + 1;
	end
	wwdt_top DUT (.clk(clk), .rst(rst), .lprcClk(lprcClk), .clockSwitchDone(clockSwitchDone),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .oscEnable(oscEnable),
		.watchdogReset(watchdogReset), .wakeUp(wakeUp), .lowPower(lowPower));
	wwdt_core_model core (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic lvl(input string what, input logic v, input logic x);
		@(negedge clk);
		check(what, 32'(v), 32'(x));
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		core.xfer(1'b1, a, d, rd, e);
	endtask
	task automatic rdr(input logic [7:0] a);
		core.xfer(1'b0, a, 32'h0, rd, e);
	endtask
	task automatic wt(input bit k, input int lim);
		n = 0;
		while ((k ? wakeSeen : wdrSeen) == b && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic per(input int t);
		check("period", 32'(n > t * 8 - 32 && n < t * 8 + 24), 32'h1);
	endtask
	task automatic t_reset;
		rdr(WWDT_CFG_OFF);
		check("cfg", rd, 32'h0000_00df);
		rdr(WWDT_RESET_CONTROL_REG_OFF);
		check("reset_control_reg", rd, 32'h0);
		lvl("osc", oscEnable, 1'b1);
		rdr(8'h10);
		check("unmapped", 32'(e), 32'h1);
		$display("test reset done");
	endtask
	task automatic t_period;
		logic [7:0] cfgs[5] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hd0};
		int ticks[5] = '{32, 64, 128, 256, 128};
		foreach (cfgs[i]) begin
			wr(WWDT_CFG_OFF, {24'h0, cfgs[i]});
			b = wdrSeen;
			wr(WWDT_CMD_OFF, 32'h1);
			wt(0, 2600);
			per(ticks[i]);
		end
		rdr(WWDT_RESET_CONTROL_REG_OFF);
		check("flag", rd & 32'h10, 32'h10);
		wr(WWDT_RESET_CONTROL_REG_OFF, 32'h0);
		rdr(WWDT_RESET_CONTROL_REG_OFF);
		check("flag clr", rd, 32'h0);
		$display("test period done");
	endtask
	task automatic t_soft;
		wr(WWDT_CFG_OFF, 32'h40);
		lvl("osc off", oscEnable, 1'b0);
		b = wdrSeen;
		wt(0, 400);
		check("off", n, 400);
		wr(WWDT_RESET_CONTROL_REG_OFF, 32'h20);
		lvl("osc on", oscEnable, 1'b1);
		wt(0, 400);
		per(32);
		wr(WWDT_RESET_CONTROL_REG_OFF, 32'h0);
		$display("test soft done");
	endtask
	task automatic t_keepalive;
		wr(WWDT_CFG_OFF, 32'hc0);
		for (int i = 0; i < 6; i++) begin
			if (i % 2 == 1) begin
				clockSwitchDone <= 1'b1;
				@(posedge clk);
				clockSwitchDone <= 1'b0;
			end else wr(WWDT_CMD_OFF, 32'h1);
			b = wdrSeen;
			wt(0, 180);
			check("alive", n, 180);
		end
		$display("test keepalive done");
	endtask
	task automatic t_window;
		b = wdrSeen;
		wr(WWDT_CMD_OFF, 32'h1);
		wr(WWDT_CMD_OFF, 32'h1);
		wt(0, 20);
		check("no window", n, 20);
		wr(WWDT_CFG_OFF, 32'h80);
		b = wdrSeen;
		wr(WWDT_CMD_OFF, 32'h1);
		wr(WWDT_CMD_OFF, 32'h1);
		wt(0, 20);
		check("early", 32'(n < 10), 32'h1);
		b = wdrSeen;
		wt(0, 210);
		wr(WWDT_CMD_OFF, 32'h1);
		wt(0, 200);
		check("late", n, 200);
		$display("test window done");
	endtask
	task automatic t_sleep;
		wr(WWDT_CFG_OFF, 32'hc0);
		for (int i = 0; i < 2; i++) begin
			b = wakeSeen;
			wr(WWDT_CMD_OFF, i ? 32'h4 : 32'h2);
			wt(1, 400);
			per(32);
			lvl("awake", lowPower, 1'b0);
			rdr(WWDT_RESET_CONTROL_REG_OFF);
			check("mode flag", rd & 32'h1c, i ? 32'h14 : 32'h18);
			core.clear_status;
			b = wdrSeen;
			wt(0, 400);
			per(32);
		end
		$display("test sleep done");
	endtask
	task automatic close_out;
		if (core.hung === 1'b1) err_total++;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_period;
		t_soft;
		t_keepalive;
		t_window;
		t_sleep;
		close_out;
	end
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		close_out;
	end
endmodule
`default_nettype wire
